// ===== logic/rfcrc_top.sv
/*
 * Receive fabric clock output selector, dynamic rate control and low-rate timer.
 * Assumes every control input is synchronous to clk_sys, which stands for both the
 * user clock 2 domain and the reference clock; the clock sources arrive as inputs.
 */
`timescale 1ns/1ps
module rfcrc_top
   import rfcrc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Clock sources.
   input wire logic rxCodingLayerClock,
   input wire logic rx_recovered_clock,
   input wire logic rx_reference_full,
   input wire logic rx_reference_half,
   input wire logic rx_programmable_divider_clock,
   input wire logic recoveredCircuitReset,
   // Output clock selection.
   input wire logic [2:0] rx_clock_out_select,
   output logic rx_fabric_clock_out,
   output logic rx_test_clock_out,
   output logic rx_coding_layer_clock_out,
   // Rate control.
   input wire logic [2:0] rx_rate_select,
   input wire logic [4:0] rx_static_divider_setting,
   input wire logic [7:0] rate_transition_time,
   input wire logic rx_rate_async_mode,
   input wire logic buffer_reset_on_rate_change,
   output logic [4:0] rxDividerValue,
   output rfcrc_rate_status_t rateStatus,
   // Delay alignment.
   input wire logic rx_delay_align_bypass,
   output logic delayAlignEnable,
   // Low-rate timer clock.
   input wire logic [5:0] low_rate_clock_divider,
   output logic lowRateTick,
   // Programmable divider.
   input wire logic rx_programmable_divider_reset,
   output logic rx_programmable_divider_reset_done
);

   // ==========================================================
   // Clock selection
   // ==========================================================
   logic recoveredGated;
   logic progGated;
   logic progDone_q;
   logic [3:0] progCnt_q;

   // The recovered clock halts while its circuit is held in reset.
   assign recoveredGated = rx_recovered_clock & ~recoveredCircuitReset;
   // The divider clock is passed on only once it is stable after a reset.
   assign progGated = rx_programmable_divider_clock & progDone_q;

   // Steer the selected source onto the main fabric output.
   always_comb begin
      case (rx_clock_out_select)
         SEL_CONST: rx_fabric_clock_out = 1'b1;
         SEL_PCS: rx_fabric_clock_out = rxCodingLayerClock;
         SEL_RECOVERED: rx_fabric_clock_out = recoveredGated;
         SEL_REF_FULL: rx_fabric_clock_out = rx_reference_full;
         SEL_REF_HALF: rx_fabric_clock_out = rx_reference_half;
         SEL_PROG_DIV: rx_fabric_clock_out = progGated;
         default: rx_fabric_clock_out = 1'b0;
      endcase
   end

   // Redundant outputs kept for compatibility; the main output is preferred.
   assign rx_test_clock_out = rx_reference_full;
   assign rx_coding_layer_clock_out = rxCodingLayerClock;

   // ==========================================================
   // Programmable divider reset
   // ==========================================================
   // Reset clears the done flag; it returns after a fixed settling time.
   always_ff @(posedge clk_sys) begin
      if (rst || rx_programmable_divider_reset) begin
         progCnt_q <= 4'h0;
         progDone_q <= 1'b0;
      end else if (progCnt_q != PROG_SETTLE_CYCLES) begin
         progCnt_q <= progCnt_q + 4'h1;
      end else begin
         progDone_q <= 1'b1;
      end
   end
   assign rx_programmable_divider_reset_done = progDone_q;

   // ==========================================================
   // Low-rate timer clock
   // ==========================================================
   logic [5:0] lowCnt_q;
   logic [5:0] lowDiv;
   logic lowTick_q;

   // A divider of zero is treated as one so the timer never stops.
   assign lowDiv = (low_rate_clock_divider == 6'h00) ? LOW_DIV_RESET_VALUE : low_rate_clock_divider;

   // One tick per divider period paces every rate change timer.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lowCnt_q <= 6'h00;
         lowTick_q <= 1'b0;
      end else if (lowCnt_q >= lowDiv - 6'h01) begin
         lowCnt_q <= 6'h00;
         lowTick_q <= 1'b1;
      end else begin
         lowCnt_q <= lowCnt_q + 6'h01;
         lowTick_q <= 1'b0;
      end
   end
   assign lowRateTick = lowTick_q;

   // ==========================================================
   // Divider value decode
   // ==========================================================
   logic [4:0] targetDiv;

   // Rate code zero uses the static setting; codes one to five force a value, six and seven keep the current one.
   always_comb begin
      case (rx_rate_select)
         RATE_STATIC: targetDiv = rx_static_divider_setting;
         RATE_DIV1: targetDiv = DIVIDE_1;
         RATE_DIV2: targetDiv = DIVIDE_2;
         RATE_DIV4: targetDiv = DIVIDE_4;
         RATE_DIV8: targetDiv = DIVIDE_8;
         RATE_DIV16: targetDiv = DIVIDE_16;
         default: targetDiv = rxDividerValue;
      endcase
   end

   // ==========================================================
   // Rate change sequence
   // ==========================================================
   rfcrc_rate_state_t state_q;
   logic [2:0] rateSel_q;
   logic [7:0] timer_q;
   logic rateChanged;
   logic timerDone;
   logic donePulse_q;

   assign rateChanged = (rx_rate_select != rateSel_q);
   assign timerDone = (state_q == RATE_WAIT) && lowTick_q && (timer_q == 8'h00) && !rateChanged;

   // Track the last rate code; a new change restarts the wait.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= RATE_IDLE;
         rateSel_q <= RATE_STATIC;
         timer_q <= 8'h00;
      end else begin
         rateSel_q <= rx_rate_select;
         case (state_q)
            RATE_IDLE: begin
               if (rateChanged) begin
                  state_q <= RATE_WAIT;
                  timer_q <= rate_transition_time;
               end
            end
            RATE_WAIT: begin
               if (rateChanged) begin
                  timer_q <= rate_transition_time;
               end else if (timerDone) begin
                  state_q <= RATE_IDLE;
               end else if (lowTick_q) begin
                  timer_q <= timer_q - 8'h01;
               end
            end
            default: state_q <= RATE_IDLE;
         endcase
      end
   end

   // Completion pulse lasts exactly one cycle.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         donePulse_q <= 1'b0;
      end else begin
         donePulse_q <= timerDone;
      end
   end

   // Async mode follows the rate code at once; sync mode applies it at the end.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rxDividerValue <= DIVIDER_RESET_VALUE;
      end else if (rx_rate_async_mode || state_q == RATE_IDLE && !rateChanged || timerDone) begin
         rxDividerValue <= targetDiv;
      end
   end

   // Status outputs; the medium reset covers the whole wait in sync mode, the buffer reset covers it whenever its option is set.
   always_comb begin
      rateStatus.rateChangeDone = donePulse_q;
      rateStatus.phyStateReport = donePulse_q;
      rateStatus.mediumReset = (state_q == RATE_WAIT) && !rx_rate_async_mode;
      rateStatus.elasticBufferReset = (state_q == RATE_WAIT) && buffer_reset_on_rate_change;
   end

   // ==========================================================
   // Delay alignment
   // ==========================================================
   // Alignment runs when the fabric leaves the bypass low.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         delayAlignEnable <= 1'b0;
      end else begin
         delayAlignEnable <= ~rx_delay_align_bypass;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   a_sel_const: assert property (@(posedge clk_sys) disable iff (rst)
      rx_clock_out_select == SEL_CONST |-> rx_fabric_clock_out)
      else $error("Select zero did not give a constant high.");
   a_sel_reserved: assert property (@(posedge clk_sys) disable iff (rst)
      rx_clock_out_select > SEL_PROG_DIV |-> !rx_fabric_clock_out)
      else $error("Reserved select passed a clock.");
   a_recov_stops: assert property (@(posedge clk_sys) disable iff (rst)
      rx_clock_out_select == SEL_RECOVERED && recoveredCircuitReset |-> !rx_fabric_clock_out)
      else $error("Recovered clock ran during its reset.");
   a_done_single: assert property (@(posedge clk_sys) disable iff (rst)
      rateStatus.rateChangeDone |=> !rateStatus.rateChangeDone)
      else $error("Rate done pulse longer than one cycle.");
   a_done_phy_pair: assert property (@(posedge clk_sys) disable iff (rst)
      rateStatus.rateChangeDone |-> rateStatus.phyStateReport && $past(state_q) == RATE_WAIT)
      else $error("Rate done without phy report or wait.");
   a_async_follow: assert property (@(posedge clk_sys) disable iff (rst)
      rx_rate_async_mode && rx_rate_select == RATE_DIV16 |=> rxDividerValue == DIVIDE_16)
      else $error("Forced divide value not applied.");
   a_static_use: assert property (@(posedge clk_sys) disable iff (rst)
      rx_rate_async_mode && rx_rate_select == RATE_STATIC |=> rxDividerValue == $past(rx_static_divider_setting))
      else $error("Static divider not applied at rate zero.");
   a_sync_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !rx_rate_async_mode && state_q == RATE_WAIT && !timerDone |=> $stable(rxDividerValue))
      else $error("Divider changed during sync reset sequence.");
   a_buf_reset: assert property (@(posedge clk_sys) disable iff (rst)
      rateChanged && buffer_reset_on_rate_change |=> rateStatus.elasticBufferReset)
      else $error("Elastic buffer reset missing on rate change.");
   a_prog_clear: assert property (@(posedge clk_sys) disable iff (rst)
      rx_programmable_divider_reset |=> !rx_programmable_divider_reset_done)
      else $error("Divider reset did not clear done.");
   a_low_tick: assert property (@(posedge clk_sys) disable iff (rst)
      lowRateTick && low_rate_clock_divider == 6'h02 && $stable(low_rate_clock_divider) |=> !lowRateTick)
      else $error("Low-rate tick too frequent.");

endmodule : rfcrc_top

// ===== include/rfcrc_pkg.sv
/*
 * Constants and carrier types for the receive fabric clock and rate control block.
 * Assumes a single 50 MHz system clock that also serves as the user clock 2 domain
 * and as the reference clock from which the low-rate timer clock is divided.
 */
package rfcrc_pkg;

   // ==========================================================
   // Output clock select codes
   // ==========================================================
   localparam logic [2:0] SEL_CONST = 3'h0;
   localparam logic [2:0] SEL_PCS = 3'h1;
   localparam logic [2:0] SEL_RECOVERED = 3'h2;
   localparam logic [2:0] SEL_REF_FULL = 3'h3;
   localparam logic [2:0] SEL_REF_HALF = 3'h4;
   localparam logic [2:0] SEL_PROG_DIV = 3'h5;

   // ==========================================================
   // Rate select codes and divide values
   // ==========================================================
   localparam logic [2:0] RATE_STATIC = 3'h0;
   localparam logic [2:0] RATE_DIV1 = 3'h1;
   localparam logic [2:0] RATE_DIV2 = 3'h2;
   localparam logic [2:0] RATE_DIV4 = 3'h3;
   localparam logic [2:0] RATE_DIV8 = 3'h4;
   localparam logic [2:0] RATE_DIV16 = 3'h5;
   localparam logic [4:0] DIVIDE_1 = 5'h01;
   localparam logic [4:0] DIVIDE_2 = 5'h02;
   localparam logic [4:0] DIVIDE_4 = 5'h04;
   localparam logic [4:0] DIVIDE_8 = 5'h08;
   localparam logic [4:0] DIVIDE_16 = 5'h10;

   // ==========================================================
   // Reset values and timing
   // ==========================================================
   localparam logic [4:0] DIVIDER_RESET_VALUE = 5'h01;
   localparam logic [5:0] LOW_DIV_RESET_VALUE = 6'h01;
   localparam int CLK_PERIOD_NS = 20;
   localparam int PROG_SETTLE_NS = 200;
   localparam logic [3:0] PROG_SETTLE_CYCLES = 4'((PROG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [0:0] {
      RATE_IDLE = 1'b0,
      RATE_WAIT = 1'b1
   } rfcrc_rate_state_t;

   // Indications produced by the rate change sequence.
   typedef struct packed {
      logic rateChangeDone;
      logic phyStateReport;
      logic mediumReset;
      logic elasticBufferReset;
   } rfcrc_rate_status_t;

endpackage : rfcrc_pkg

// ===== tb/rfcrc_fabric_model.sv
/*
 * Model of the user fabric logic that faces the receive clock and rate control block.
 * Assumes clk_sys is the user clock 2 domain and that the bench reports buffer use and clock loss.
 */
`timescale 1ns/1ps
module rfcrc_fabric_model (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Fabric state.
   input wire logic bufferUsed,
   input wire logic sourceLost,
   // Controls toward the block.
   output logic rx_delay_align_bypass,
   output logic rx_programmable_divider_reset
);
   // ==========================================================
   // Control outputs
   // ==========================================================
   // Bypass alignment while the buffer is used, and reset the divider after a clock loss.
   always_ff @(posedge clk_sys) begin
      rx_delay_align_bypass <= bufferUsed;
      rx_programmable_divider_reset <= rst | sourceLost;
   end
endmodule : rfcrc_fabric_model

// ===== tb/tb_rx_fabric_clock_rate_control.sv
/*
 * Self-checking bench for the receive fabric clock and rate control block.
 * Assumes the design carries its own assertions and that clk_sys runs at 50 MHz.
 */
`timescale 1ns/1ps
module tb_rx_fabric_clock_rate_control;
   import rfcrc_pkg::*;
   typedef struct packed {logic [2:0] rate; logic [4:0] stat; logic [4:0] div;} rfcrc_row_t;
   // ==========================================================
   // Signals
   // ==========================================================
   logic clk_sys = 1'b0, rst = 1'b1, cod = 1'b0, rec = 1'b0, full = 1'b0, half = 1'b0, prog = 1'b0;
   logic recReset = 1'b0, bufferUsed = 1'b0, sourceLost = 1'b0, asyncMode = 1'b1, bufReset = 1'b0;
   logic [2:0] sel = 3'h3, rate = 3'h0;
   logic [4:0] stat = 5'h01; // Agrees with rate code zero at start.
   logic [7:0] transTime = 8'h02;
   logic [5:0] lowDiv = 6'h02; // Gives a 25 MHz tick from 50 MHz.
   logic fabOut, testOut, codOut, bypass, progReset, alignEn, tickOut, progDone;
   logic [4:0] divOut;
   rfcrc_rate_status_t st;
   int errors = 0, checks_done = 0, n, k, m;
   wire logic [6:0] srcs = {1'b0, prog, half, full, rec, cod, 1'b1};
   localparam rfcrc_row_t ROWS [9] = '{'{3'h1, 5'h08, 5'h01}, '{3'h0, 5'h08, 5'h08}, '{3'h2, 5'h08, 5'h02},
      '{3'h3, 5'h08, 5'h04}, '{3'h4, 5'h08, 5'h08}, '{3'h5, 5'h08, 5'h10}, '{3'h6, 5'h08, 5'h10},
      '{3'h0, 5'h02, 5'h02}, '{3'h7, 5'h02, 5'h02}};
   // Clocks with unrelated half periods.
   initial forever #10 clk_sys = ~clk_sys;
   initial forever #3 cod = ~cod;
   initial forever #4 rec = ~rec;
   initial forever #5 full = ~full;
   initial forever #7 half = ~half;
   initial forever #9 prog = ~prog;
   // ==========================================================
   // Design and fabric model
   // ==========================================================
   rfcrc_top dut (.clk_sys(clk_sys), .rst(rst), .rxCodingLayerClock(cod), .rx_recovered_clock(rec),
      .rx_reference_full(full), .rx_reference_half(half), .rx_programmable_divider_clock(prog),
      .recoveredCircuitReset(recReset), .rx_clock_out_select(sel), .rx_fabric_clock_out(fabOut),
      .rx_test_clock_out(testOut), .rx_coding_layer_clock_out(codOut), .rx_rate_select(rate),
      .rx_static_divider_setting(stat), .rate_transition_time(transTime), .rx_rate_async_mode(asyncMode),
      .buffer_reset_on_rate_change(bufReset), .rxDividerValue(divOut), .rateStatus(st),
      .rx_delay_align_bypass(bypass), .delayAlignEnable(alignEn), .low_rate_clock_divider(lowDiv),
      .lowRateTick(tickOut), .rx_programmable_divider_reset(progReset),
      .rx_programmable_divider_reset_done(progDone));
   rfcrc_fabric_model model (.clk_sys(clk_sys), .rst(rst), .bufferUsed(bufferUsed), .sourceLost(sourceLost),
      .rx_delay_align_bypass(bypass), .rx_programmable_divider_reset(progReset));
   // ==========================================================
   // Tasks
   // ==========================================================
   // Compares one value and counts it.
   task automatic check(input logic [4:0] seen, input logic [4:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Moves just past the next edge, where no source clock toggles.
   task automatic step();
      @(posedge clk_sys);
      #0.5;
   endtask : step
   // Prints the counts and the verdict, then stops.
   task automatic final_report();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   // Cuts a hang short.
   initial begin
      #60000;
      errors++;
      final_report();
   end
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (2) step();
      check(divOut, DIVIDE_1);
      check(5'({st, alignEn}), 5'h00);
      @(posedge clk_sys) rst <= 1'b0;
      for (n = 0; n < 20 && tickOut !== 1'b1; n++) step();
      step();
      for (n = 1; n < 20 && tickOut !== 1'b1; n++) step();
      check(5'(n), 5'(lowDiv));
      repeat (12) step();
      // Every select code, reserved ones included, with the redundant copies.
      for (k = 0; k < 8; k++) begin
         @(posedge clk_sys) sel <= 3'(k);
         for (n = 0; n < 4; n++) begin
            step();
            check(5'(fabOut), 5'(srcs[k < 6 ? k : 6]));
            check(5'({testOut, codOut}), 5'({full, cod}));
         end
      end
      // Rate rows in asynchronous mode.
      foreach (ROWS[i]) begin
         @(posedge clk_sys) begin
            rate <= ROWS[i].rate;
            stat <= ROWS[i].stat;
         end
         step();
         step();
         check(divOut, ROWS[i].div);
      end
      repeat (30) step();
      // Synchronous change with the buffer reset option.
      @(posedge clk_sys) begin
         asyncMode <= 1'b0;
         bufReset <= 1'b1;
         rate <= 3'h3;
      end
      step();
      step();
      check(5'({st.mediumReset, st.elasticBufferReset}), 5'h03);
      check(divOut, DIVIDE_2);
      for (n = 2; n < 40 && st.rateChangeDone !== 1'b1; n++) step();
      check(5'(n >= 6 && n <= 7), 5'h01);
      check(5'(st.phyStateReport), 5'h01);
      check(divOut, DIVIDE_4);
      step();
      check(5'({st.rateChangeDone, st.mediumReset, st.elasticBufferReset}), 5'h00);
      // Back-to-back changes without the option give one pulse.
      @(posedge clk_sys) begin
         bufReset <= 1'b0;
         rate <= 3'h4;
      end
      @(posedge clk_sys) rate <= 3'h5;
      k = 0;
      m = 0;
      for (n = 0; n < 40; n++) begin
         step();
         k += int'(st.rateChangeDone);
         m += int'(st.elasticBufferReset);
      end
      check(5'(k), 5'h01);
      check(5'(m), 5'h00);
      check(divOut, DIVIDE_16);
      // Buffer use drives the bypass, which turns alignment off.
      @(posedge clk_sys) bufferUsed <= 1'b1;
      repeat (3) step();
      check(5'(alignEn), 5'h00);
      @(posedge clk_sys) bufferUsed <= 1'b0;
      repeat (3) step();
      check(5'(alignEn), 5'h01);
      // Recovered clock held while its circuit resets.
      @(posedge clk_sys) begin
         recReset <= 1'b1;
         sel <= 3'h2;
      end
      for (n = 0; n < 6; n++) begin
         step();
         check(5'(fabOut), 5'h00);
      end
      // Divider reset after a clock loss.
      @(posedge clk_sys) begin
         sourceLost <= 1'b1;
         sel <= 3'h5;
      end
      repeat (3) step();
      check(5'({progDone, fabOut}), 5'h00);
      @(posedge clk_sys) sourceLost <= 1'b0;
      for (n = 0; n < 20 && progDone !== 1'b1; n++) step();
      check(5'(n >= PROG_SETTLE_CYCLES + 1 && n <= PROG_SETTLE_CYCLES + 3), 5'h01);
      // Reset in the middle of a rate change.
      @(posedge clk_sys) rate <= 3'h1;
      repeat (3) step();
      @(posedge clk_sys) rst <= 1'b1;
      step();
      check(divOut, DIVIDE_1);
      check(5'(st), 5'h00);
      @(posedge clk_sys) rst <= 1'b0;
      // A nonzero rate code at release counts as a change and gives one pulse.
      step();
      check(5'(st.mediumReset), 5'h01);
      k = 0;
      for (n = 0; n < 19; n++) begin
         step();
         k += int'(st.rateChangeDone);
      end
      check(5'(k), 5'h01);
      final_report();
   end
endmodule : tb_rx_fabric_clock_rate_control
